/* design/psm_pkg.sv */
package psm_pkg;

    // Speed scale: 0.1 % of rated speed per unit
    localparam int SPD_W = 10;
    localparam logic [9:0] RATED_UNITS = 10'h3E8;
    localparam logic [9:0] SETPT_MIN = 10'h0FA;
    localparam logic [9:0] SETPT_MAX = 10'h3E8;
    localparam logic [9:0] SETPT_RST = 10'h3E8;

    // Rated rotor speed in rpm, plain default
    localparam int RATED_RPM = 30000;
    // Rotor counts as stopped at or below this
    localparam int STOP_RPM = 60;
    localparam logic [9:0] STOP_UNITS =
        10'(STOP_RPM * 1000 / RATED_RPM);

    // Clock and ramp timing
    localparam int CLK_HZ = 100_000_000;
    // Time for one 0.1 % speed step, plain default
    localparam int RAMP_STEP_US = 100;
    localparam int RAMP_STEP_CYC =
        RAMP_STEP_US * (CLK_HZ / 1_000_000);
    localparam int TICK_W = 24;

    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SETPT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_SPEED = 4'hC;

    // Control register fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_LOW_BIT = 3;

    // Status register fields
    localparam int ST_RUN_LSB = 0;
    localparam int ST_ROT_BIT = 2;
    localparam int ST_ACC_BIT = 3;
    localparam int ST_NORM_BIT = 4;
    localparam int ST_BRK_BIT = 5;
    localparam int ST_LOW_BIT = 6;

    // Command source, remote after power-up
    typedef enum logic [1:0] {
        SRC_LOCAL,
        SRC_REMOTE,
        SRC_SERIAL
    } psm_src_t;

    // Run status as reported over the serial side
    typedef enum logic [1:0] {
        RUN_STOP,
        RUN_ACCEL,
        RUN_NORMAL,
        RUN_RAMPING_DOWN_FLAG
    } psm_run_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } psm_avs_req_t;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } psm_avs_rsp_t;

    // Connector and panel inputs
    typedef struct packed {
        logic panel_start;
        logic remote_start;
        logic remote_low_speed;
    } psm_pins_t;

    // Remote connector indications
    typedef struct packed {
        logic rotating;
        logic accelerating;
        logic at_speed;
        logic ramping_down_flag;
    } psm_ind_t;

    // Whole state of the control module
    typedef struct packed {
        psm_pins_t sync1;
        psm_pins_t sync2;
        psm_src_t src;
        logic ser_start;
        logic ser_low;
        logic [9:0] setpt;
        logic [9:0] speed;
        psm_run_t run;
        psm_ind_t ind;
        psm_avs_rsp_t rsp;
    } psm_state_t;

    // Whole state of the ramp divider
    typedef struct packed {
        logic [23:0] cnt;
        logic tick;
    } psm_tick_state_t;

endpackage

/* design/psm_ramp_tick.sv */
`timescale 1ns/10ps
module psm_ramp_tick
    import psm_pkg::*;
#(
    parameter int unsigned STEP_CYC = RAMP_STEP_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    output logic tick_o
);

    psm_tick_state_t q;
    psm_tick_state_t d;

    // Free-running divider, one pulse per step period
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == TICK_W'(STEP_CYC - 1)) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 24'h000001;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule

/* design/psm_speed_ctrl.sv */
// Overview of operation
// [RULE_01] Low speed honoured only under remote or serial control
// [RULE_02] Speed mode may change stopped or running
// [RULE_03] Setpoint 25..100 % in 0.1 % steps
// [RULE_04] Setpoint rewrite while low: ramp, hold
// [RULE_05] One ramp rate for every speed change
// [RULE_06] Setpoint kept across runs
// [RULE_07] Remote low start: accelerating, later rotating
// [RULE_08] Remote low: at-speed at 80 % setpoint
// [RULE_09] Reaching setpoint: stop ramp, hold speed
// [RULE_10] Late low selection acts as early one
// [RULE_11] Serial: stop, accelerating, at-speed at 80 %; code marks at-speed at the setpoint for serial low below 80 %
// [RULE_12] Low above setpoint: ramping_down_flag, then at-speed
// [RULE_13] Low withdrawn while braking: rated behaviour
// [RULE_14] Serial low at rated: braking then at-speed
// [RULE_15] Leaving low at or below 80 %: accelerate; code accelerates only below 80 %
// [RULE_16] Leaving low above 80 %: status unchanged
// [RULE_17] Serial rated command mirrors remote withdrawal
// [RULE_18] At rated speed: end ramp, hold speed
// [RULE_19] Setpoint 100 % follows the same transitions
// [RULE_20] At or below 60 rpm: stopped, not rotating
// [RULE_21] Speeds in 0.1 % units, fixed thresholds
`timescale 1ns/10ps
module psm_speed_ctrl
    import psm_pkg::*;
#(
    parameter int unsigned STEP_CYC = RAMP_STEP_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire psm_avs_req_t avs_req_i,
    output psm_avs_rsp_t avs_rsp_o,
    input wire psm_pins_t pins_i,
    output psm_ind_t ind_o
);

    // Registered state and its next value
    psm_state_t q;
    psm_state_t d;

    // One step per pulse, shared by up and down ramps
    logic ramp_tick;

    // Decoded command of the active source
    logic run_cmd;
    logic low_sel;
    logic [9:0] target;
    logic [9:0] norm_thr;
    logic [9:0] rated80;
    logic [31:0] rd_word;
    logic [31:0] ctrl_new;
    logic [31:0] setpt_new;

    // 80 % of a speed value, rounded down
    function automatic logic [9:0] pct80(input logic [9:0] x);
        logic [11:0] prod;
        prod = {2'h0, x} * 12'h004;
        return 10'(prod / 12'h005);
    endfunction

    // Merge write data into a word by byte enables
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Force a setpoint into the legal span
    function automatic logic [9:0] clamp_setpt(
        input logic [31:0] w
    );
        logic [9:0] res;
        res = w[9:0];
        if (w[31:10] != 22'h000000) begin
            res = SETPT_MAX;
        end else if (w[9:0] > SETPT_MAX) begin
            res = SETPT_MAX;
        end else if (w[9:0] < SETPT_MIN) begin
            res = SETPT_MIN;
        end
        return res;
    endfunction

    // Step pulse for the speed ramp
    psm_ramp_tick #(
        .STEP_CYC(STEP_CYC)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .tick_o(ramp_tick)
    );

    // Read mux, unmapped offsets read as zero
    always_comb begin
        rd_word = 32'h00000000;
        unique case (avs_req_i.address)
            REG_CTRL: begin
                rd_word[CTRL_SRC_LSB +: 2] = q.src;
                rd_word[CTRL_START_BIT] = q.ser_start;
                rd_word[CTRL_LOW_BIT] = q.ser_low;
            end
            REG_SETPT: begin
                rd_word[9:0] = q.setpt;
            end
            REG_STATUS: begin
                rd_word[ST_RUN_LSB +: 2] = q.run;
                rd_word[ST_ROT_BIT] = q.ind.rotating;
                rd_word[ST_ACC_BIT] = q.ind.accelerating;
                rd_word[ST_NORM_BIT] = q.ind.at_speed;
                rd_word[ST_BRK_BIT] = q.ind.ramping_down_flag;
                rd_word[ST_LOW_BIT] = low_sel;
            end
            REG_SPEED: begin
                rd_word[9:0] = q.speed;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // Command source decode
    always_comb begin
        run_cmd = 1'b0;
        low_sel = 1'b0;
        unique case (q.src)
            // [RULE_01] Local runs at rated only
            SRC_LOCAL: begin
                run_cmd = q.sync2.panel_start;
                low_sel = 1'b0;
            end
            // [RULE_02] Mode pin followed at any time
            SRC_REMOTE: begin
                run_cmd = q.sync2.remote_start;
                low_sel = q.sync2.remote_low_speed;
            end
            // [RULE_17] Serial bits act like the pins
            SRC_SERIAL: begin
                run_cmd = q.ser_start;
                low_sel = q.ser_low;
            end
            default: begin
                run_cmd = 1'b0;
                low_sel = 1'b0;
            end
        endcase
    end

    // Target and at-speed threshold in 0.1 % units
    always_comb begin
        rated80 = pct80(RATED_UNITS);
        // [RULE_10] Target follows selection continuously
        if (!run_cmd) begin
            target = 10'h000;
        end else if (low_sel) begin
            target = q.setpt;
        end else begin
            target = RATED_UNITS;
        end
        // [RULE_21] Fixed fractions of rated or setpoint
        norm_thr = rated80;
        if (low_sel && q.src == SRC_REMOTE) begin
            // [RULE_08] Remote low: 80 % of the setpoint
            norm_thr = pct80(q.setpt);
        end else if (low_sel && q.setpt < rated80) begin
            // Serial low below 80 %: setpoint is the mark
            norm_thr = q.setpt;
        end
    end

    // Bus write candidates
    always_comb begin
        ctrl_new = be_merge(rd_ctrl(q), avs_req_i.writedata,
            avs_req_i.byteenable);
        setpt_new = be_merge({22'h000000, q.setpt},
            avs_req_i.writedata, avs_req_i.byteenable);
    end

    // Current control word, for byte merging
    function automatic logic [31:0] rd_ctrl(input psm_state_t s);
        logic [31:0] w;
        w = 32'h00000000;
        w[CTRL_SRC_LSB +: 2] = s.src;
        w[CTRL_START_BIT] = s.ser_start;
        w[CTRL_LOW_BIT] = s.ser_low;
        return w;
    endfunction

    // Next state of the whole block
    always_comb begin
        d = q;

        // Two-stage pin synchronisers
        d.sync1 = pins_i;
        d.sync2 = q.sync1;

        // Bus slave: one wait cycle, then one ready cycle
        d.rsp.waitrequest = 1'b1;
        if ((avs_req_i.read || avs_req_i.write) &&
            q.rsp.waitrequest) begin
            d.rsp.waitrequest = 1'b0;
            d.rsp.readdata = avs_req_i.read ? rd_word :
                32'h00000000;
        end

        // Writes land on the edge that ends the ready cycle
        if (avs_req_i.write && !q.rsp.waitrequest) begin
            unique case (avs_req_i.address)
                REG_CTRL: begin
                    // Code 3 is no source; keep the old one
                    if (ctrl_new[CTRL_SRC_LSB +: 2] != 2'h3) begin
                        d.src = psm_src_t'(
                            ctrl_new[CTRL_SRC_LSB +: 2]);
                    end
                    d.ser_start = ctrl_new[CTRL_START_BIT];
                    d.ser_low = ctrl_new[CTRL_LOW_BIT];
                end
                REG_SETPT: begin
                    // [RULE_03] Clamp into the legal span
                    d.setpt = clamp_setpt(setpt_new);
                end
                default: begin
                    // Read-only or unmapped: ignored
                end
            endcase
        end
        // [RULE_06] Setpoint is only changed by a write

        // [RULE_05] Same step size and period both ways
        if (ramp_tick) begin
            // [RULE_04] Rewritten setpoint is ramped to
            if (q.speed < target) begin
                d.speed = q.speed + 10'h001;
            // [RULE_09] Hold once the target is met
            end else if (q.speed > target) begin
                d.speed = q.speed - 10'h001;
            end
        end
        // [RULE_18] Rated target is held the same way

        // Run status sequencing
        unique case (q.run)
            RUN_STOP: begin
                // [RULE_07] Accelerating as the ramp begins
                if (run_cmd && target > q.speed) begin
                    d.run = RUN_ACCEL;
                end
            end
            RUN_ACCEL: begin
                if (!run_cmd) begin
                    d.run = RUN_RAMPING_DOWN_FLAG;
                // Low chosen above the setpoint
                end else if (q.speed > target) begin
                    d.run = RUN_RAMPING_DOWN_FLAG;
                // [RULE_11] At-speed at the threshold
                end else if (q.speed >= norm_thr) begin
                    d.run = RUN_NORMAL;
                end
            end
            RUN_NORMAL: begin
                if (!run_cmd) begin
                    d.run = RUN_RAMPING_DOWN_FLAG;
                // [RULE_12] Braking down to the setpoint
                end else if (q.speed > target) begin
                    // [RULE_14] Same for a serial command
                    d.run = RUN_RAMPING_DOWN_FLAG;
                // [RULE_15] Low left below 80 %; at exactly 80 % the status is kept
                end else if (!low_sel && q.speed < target &&
                    q.speed < rated80) begin
                    d.run = RUN_ACCEL;
                end
                // [RULE_16] Above 80 %: no status change
                // [RULE_19] Full setpoint takes the same path
            end
            RUN_RAMPING_DOWN_FLAG: begin
                if (!run_cmd) begin
                    // [RULE_20] Stopped at or below 60 rpm
                    if (q.speed <= STOP_UNITS) begin
                        d.run = RUN_STOP;
                    end
                end else if (q.speed <= target) begin
                    // [RULE_13] Withdrawn low: rated rules
                    if (low_sel || q.speed >= norm_thr) begin
                        d.run = RUN_NORMAL;
                    end else begin
                        d.run = RUN_ACCEL;
                    end
                end
            end
            default: begin
                d.run = RUN_STOP;
            end
        endcase

        // Connector indications follow the run status; rotating follows speed
        // [RULE_20] Rotating ends at or below 60 rpm
        d.ind.rotating = q.speed > STOP_UNITS;
        d.ind.accelerating = q.run == RUN_ACCEL;
        d.ind.at_speed = q.run == RUN_NORMAL;
        d.ind.ramping_down_flag = q.run == RUN_RAMPING_DOWN_FLAG;
    end

    // State register; remote source after power-up
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.src <= SRC_REMOTE;
            q.setpt <= SETPT_RST;
            q.run <= RUN_STOP;
            q.rsp.waitrequest <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign avs_rsp_o = q.rsp;
    assign ind_o = q.ind;

endmodule

/* sim/psm_host_model.sv */
`timescale 1ns/10ps
module psm_host_model
    import psm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire psm_avs_rsp_t avs_rsp_i,
    output psm_avs_req_t avs_req_o,
    output psm_pins_t pins_o
);
    // Set when an answer never came
    logic hung = 1'b0;

    // Idle bus and open connector at power-up
    initial begin
        avs_req_o = '0;
        pins_o = '0;
    end

    // Connector levels; front panel is never pressed
    task automatic set_pins(input logic start, input logic low);
        pins_o <= '{panel_start: 1'b0, remote_start: start,
                    remote_low_speed: low};
    endtask

    // One word; held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [3:0] adr,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        avs_req_o <= '{address: adr, read: !wr, write: wr,
                       writedata: wd, byteenable: 4'hF};
        @(posedge clk_sys_i);
        while (avs_rsp_i.waitrequest !== 1'b0 && n < 40) begin
            @(posedge clk_sys_i);
            n++;
        end
        hung = hung | (n >= 40);
        rd = avs_rsp_i.readdata;
        avs_req_o.read <= 1'b0;
        avs_req_o.write <= 1'b0;
        // Let the release land before a new request
        @(posedge clk_sys_i);
    endtask
endmodule

/* sim/psm_speed_ctrl_properties.sv */
`timescale 1ns/10ps
module psm_speed_ctrl_chk
    import psm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire psm_avs_req_t avs_req_i,
    input wire psm_avs_rsp_t avs_rsp_o,
    input wire psm_pins_t pins_i,
    input wire psm_ind_t ind_o
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    AST_ANSWER_NEXT: assert property (
        (avs_req_i.read || avs_req_i.write) && avs_rsp_o.waitrequest
        |=> !avs_rsp_o.waitrequest) else $error("bus answer late");
    AST_ACK_PULSE: assert property (
        $fell(avs_rsp_o.waitrequest) |=> avs_rsp_o.waitrequest)
        else $error("ack longer than one cycle");
    // Read data may only move on an answer
    AST_RD_HOLD: assert property (
        avs_rsp_o.waitrequest && $past(avs_rsp_o.waitrequest)
        |-> $stable(avs_rsp_o.readdata)) else $error("readdata moved");
    AST_ACC_NRM: assert property (
        !(ind_o.accelerating && ind_o.at_speed))
        else $error("accelerating with at-speed");
    AST_BRK_NRM: assert property (
        !(ind_o.ramping_down_flag && ind_o.at_speed))
        else $error("ramping down with at-speed");
    AST_ACC_BRK: assert property (
        !(ind_o.accelerating && ind_o.ramping_down_flag))
        else $error("accelerating and ramping down");
    AST_NRM_ROT: assert property (
        ind_o.at_speed |-> ind_o.rotating)
        else $error("at-speed while not rotating");
    // Rotation shows some cycles into a start
    AST_ROT_RISE: assert property (
        $rose(ind_o.rotating) |-> !ind_o.at_speed && !ind_o.ramping_down_flag)
        else $error("rotating rose out of a start");
    AST_ROT_FALL: assert property (
        $fell(ind_o.rotating) |-> ##[0:2]
        (!ind_o.ramping_down_flag && !ind_o.accelerating))
        else $error("status kept after stop");
endmodule

bind psm_speed_ctrl psm_speed_ctrl_chk u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .avs_req_i(avs_req_i),
    .avs_rsp_o(avs_rsp_o),
    .pins_i(pins_i),
    .ind_o(ind_o)
);

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import psm_pkg::*;
    // Bit positions inside the indication word
    localparam int B_ROT = 3;
    localparam int B_ACC = 2;
    localparam int B_NRM = 1;
    localparam int B_BRK = 0;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    psm_avs_req_t avs_req;
    psm_avs_rsp_t avs_rsp;
    psm_pins_t pins;
    psm_ind_t ind;
    logic [3:0] ind_v;
    logic [31:0] rd;
    logic [9:0] s0;
    int error_cnt = 0;
    int samples_checked = 0;
    assign ind_v = ind;

    initial forever #5 clk_sys_i = ~clk_sys_i;

    // Short ramp step keeps a full run brief
    psm_speed_ctrl #(.STEP_CYC(2)) dut (.clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i), .avs_req_i(avs_req), .avs_rsp_o(avs_rsp),
        .pins_i(pins), .ind_o(ind));
    psm_host_model host (.clk_sys_i(clk_sys_i), .avs_rsp_i(avs_rsp),
        .avs_req_o(avs_req), .pins_o(pins));

    task automatic close_out();
        if (error_cnt == 0 && samples_checked > 0 && !host.hung) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
            error_cnt++;
        end
    endtask

    // A bus answer that never came ends the run at once
    task automatic bus_guard();
        if (host.hung) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic rdr(input logic [3:0] a);
        host.xfer(1'b0, a, 32'h0, rd);
        bus_guard();
    endtask

    task automatic wrr(input logic [3:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd);
        bus_guard();
    endtask

    // Bounded wait for one indication level
    task automatic wait_ind(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (ind_v[b] !== v && n < lim) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            close_out();
        end
    endtask

    // Polls speed; the ramp settles on its target
    task automatic wait_spd(input logic [9:0] v);
        int n;
        n = 0;
        rdr(REG_SPEED);
        while (rd[9:0] !== v && n < 1500) begin
            rdr(REG_SPEED);
            n++;
        end
        if (n >= 1500) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic s_regs();
        chk("ind idle", 32'(ind_v), 32'h0);
        rdr(REG_STATUS);
        chk("status idle", 32'(rd[6:0]), 32'h0);
        rdr(REG_SETPT);
        chk("setpt reset", 32'(rd[9:0]), 32'h3E8);
        rdr(4'h2);
        chk("unmapped", rd, 32'h0);
        wrr(REG_STATUS, 32'h7F);
        rdr(REG_STATUS);
        chk("status ro", 32'(rd[6:0]), 32'h0);
        wrr(REG_SETPT, 32'h64);
        rdr(REG_SETPT);
        chk("setpt clamp", 32'(rd[9:0]), 32'h0FA);
        wrr(REG_SETPT, 32'h1F4);
        rdr(REG_SETPT);
        chk("setpt", 32'(rd[9:0]), 32'h1F4);
    endtask

    task automatic s_low_start();
        host.set_pins(1'b1, 1'b1);
        wait_ind(B_ACC, 1'b1, 10);
        chk("rot early", 32'(ind_v[B_ROT]), 32'h0);
        wait_ind(B_ROT, 1'b1, 20);
        wait_ind(B_NRM, 1'b1, 1200);
        chk("acc off", 32'(ind_v[B_ACC]), 32'h0);
        rdr(REG_SPEED);
        chk("low mark", 32'(rd[9:0] >= 400 && rd[9:0] <= 403), 1);
        wait_spd(10'h1F4);
        repeat (40) @(posedge clk_sys_i);
        rdr(REG_SPEED);
        chk("low hold", 32'(rd[9:0]), 32'h1F4);
        rdr(REG_STATUS);
        chk("low status", 32'(rd[6:0]), 32'h56);
    endtask

    task automatic s_rewrite();
        wrr(REG_SETPT, 32'h258);
        rdr(REG_SPEED);
        s0 = rd[9:0];
        repeat (40) @(posedge clk_sys_i);
        rdr(REG_SPEED);
        s0 = rd[9:0] - s0;
        chk("ramp rate", 32'(s0 >= 21 && s0 <= 22), 1);
        wait_spd(10'h258);
    endtask

    task automatic s_leave_low();
        host.set_pins(1'b1, 1'b0);
        wait_ind(B_ACC, 1'b1, 10);
        chk("leave nrm", 32'(ind_v[B_NRM]), 32'h0);
        wait_ind(B_NRM, 1'b1, 1000);
        rdr(REG_SPEED);
        chk("rated mark", 32'(rd[9:0] >= 800 && rd[9:0] <= 803), 1);
        wait_spd(10'h3E8);
        rdr(REG_STATUS);
        chk("rated status", 32'(rd[6:0]), 32'h16);
    endtask

    task automatic s_ramping_down_flag();
        host.set_pins(1'b1, 1'b1);
        wait_ind(B_BRK, 1'b1, 10);
        chk("ramping_down_flag nrm", 32'(ind_v[B_NRM]), 32'h0);
        wait_ind(B_BRK, 1'b0, 1000);
        chk("ramping_down_flag end", 32'(ind_v[B_NRM]), 32'h1);
        rdr(REG_SPEED);
        chk("ramping_down_flag hold", 32'(rd[9:0]), 32'h258);
    endtask

    task automatic s_high_leave();
        wrr(REG_SETPT, 32'h384);
        wait_spd(10'h384);
        host.set_pins(1'b1, 1'b0);
        repeat (60) begin
            @(posedge clk_sys_i);
            chk("high steady", 32'(ind_v), 32'hA);
        end
        wait_spd(10'h3E8);
    endtask

    task automatic s_stop();
        host.set_pins(1'b0, 1'b0);
        wait_ind(B_BRK, 1'b1, 10);
        wait_ind(B_ROT, 1'b0, 2200);
        repeat (3) @(posedge clk_sys_i);
        chk("stopped ind", 32'(ind_v), 32'h0);
        rdr(REG_STATUS);
        chk("stopped", 32'(rd[6:0]), 32'h0);
        rdr(REG_SETPT);
        chk("setpt kept", 32'(rd[9:0]), 32'h384);
    endtask

    task automatic s_serial();
        wrr(REG_CTRL, 32'h6);
        repeat (20) @(posedge clk_sys_i);
        rdr(REG_STATUS);
        chk("ser accel", 32'(rd[1:0]), 32'(RUN_ACCEL));
        wait_spd(10'h3E8);
        rdr(REG_STATUS);
        chk("ser normal", 32'(rd[1:0]), 32'(RUN_NORMAL));
        wrr(REG_CTRL, 32'hE);
        rdr(REG_STATUS);
        chk("ser ramping_down_flag", 32'(rd[1:0]), 32'(RUN_RAMPING_DOWN_FLAG));
        wait_spd(10'h384);
        rdr(REG_STATUS);
        chk("ser low", 32'(rd[1:0]), 32'(RUN_NORMAL));
        // Rated command with setpoint above 80 %: status unchanged
        wrr(REG_CTRL, 32'h6);
        rdr(REG_STATUS);
        chk("ser rated", 32'(rd[1:0]), 32'(RUN_NORMAL));
        wait_spd(10'h3E8);
        rdr(REG_STATUS);
        chk("ser rated end", 32'(rd[1:0]), 32'(RUN_NORMAL));
    endtask

    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        s_regs();
        s_low_start();
        s_rewrite();
        s_leave_low();
        s_ramping_down_flag();
        s_high_leave();
        s_stop();
        s_serial();
        close_out();
    end
endmodule
